// ### inc/cmd_decode_pkg.sv
/*
  Constants and carrier types for the DRAM command decoder.
  Assumes every design file imports this package.
*/
package cmd_decode_pkg;

  localparam int NUM_BANKS  = 8;
  localparam int BANK_W     = 3;
  localparam int ADDR_W     = 15;
  localparam int COL_W      = 10;
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int AP_BIT     = 10;
  localparam int BC_BIT     = 12;
  localparam int FIFO_DEPTH = 8;
  localparam int WR_W       = DATA_W + 2 + 1;

  // Termination select fields in mode registers one and two
  localparam int MR1_RTT_LO = 2;
  localparam int MR1_RTT_MI = 6;
  localparam int MR1_RTT_HI = 9;
  localparam int MR2_RTT_LO = 9;
  localparam int MR2_RTT_HI = 10;
  localparam logic [BANK_W-1:0] MR_SEL_ONE = 3'h1;
  localparam logic [BANK_W-1:0] MR_SEL_TWO = 3'h2;

  localparam logic [3:0] BEATS_FOUR  = 4'h4;
  localparam logic [3:0] BEATS_EIGHT = 4'h8;

  // Decoded command codes
  typedef enum logic [3:0] {
    CMD_DESELECT  = 4'h0,
    CMD_NOP       = 4'h1,
    CMD_ACTIVATE  = 4'h2,
    CMD_READ      = 4'h3,
    CMD_WRITE     = 4'h4,
    CMD_PRECHARGE = 4'h5,
    CMD_MODE_SET  = 4'h6,
    CMD_REFRESH   = 4'h7,
    CMD_SREF_IN   = 4'h8,
    CMD_PDOWN_IN  = 4'h9,
    CMD_LP_EXIT   = 4'ha,
    CMD_CALIBRATE = 4'hb,
    CMD_ILLEGAL   = 4'hf
  } cmd_t;

  // Power state, one-hot
  typedef enum logic [2:0] {
    PWR_ON    = 3'b001,
    PWR_SREF  = 3'b010,
    PWR_PDOWN = 3'b100
  } pwr_t;

  // Command pins as sampled
  typedef struct packed {
    logic              cs_n;
    logic              ras_n;
    logic              cas_n;
    logic              we_n;
    logic              cke;
    logic              odt;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
  } cmd_pins_t;

  // One decoded command report
  typedef struct packed {
    cmd_t              cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] row;
    logic [COL_W-1:0]  col;
    logic [3:0]        beats;
    logic              auto_pre;
    logic              all_banks;
    logic              cal_long;
  } cmd_info_t;

  // One write beat with its byte masks
  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic              lower_byte_write_mask;
    logic              upper_byte_write_mask;
    logic              last;
  } wr_beat_t;

endpackage : cmd_decode_pkg

// ### design/beat_fifo.sv
/*
  Small synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module beat_fifo #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  import cmd_decode_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [PW:0]                 cnt;
  } fifo_st_t;

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  // Full and empty come straight from the count
  assign o_ready = (st_q.cnt != (PW+1)'(DEPTH));
  assign o_valid = (st_q.cnt != '0);
  assign o_data  = st_q.mem[st_q.rp];
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  // Pointer and count update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wp] = i_data;
      st_d.wp = (st_q.wp == PW'(DEPTH-1)) ? '0 : st_q.wp + PW'(1);
    end
    if (pop) begin
      st_d.rp = (st_q.rp == PW'(DEPTH-1)) ? '0 : st_q.rp + PW'(1);
    end
    st_d.cnt = st_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Storage clears with the pointers, so the head reads zero after reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      st_q.wp  <= '0;
      st_q.rp  <= '0;
      st_q.cnt <= '0;
      st_q.mem <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : beat_fifo

// ### design/dram_cmd_decoder.sv
/*
  Command decoder and pin control of a DDR DRAM device.
  Assumes the command pins and the data strobe come from another clock
  domain; all are sampled by i_clk_sys and the command clock edges are
  found by edge detection. Reset pin is asynchronous active low.
*/
`timescale 1ns/1ps
module dram_cmd_decoder #(
  parameter int NUM_BANKS = cmd_decode_pkg::NUM_BANKS,
  parameter int DEPTH     = cmd_decode_pkg::FIFO_DEPTH
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_resetn,
  input  wire logic                      i_dram_reset_n,
  input  wire logic                      i_ck,
  input  wire cmd_decode_pkg::cmd_pins_t i_pins,
  input  wire logic                      i_dqs,
  input  wire logic [cmd_decode_pkg::DATA_W-1:0] i_dq,
  input  wire logic                      i_lower_byte_write_mask,
  input  wire logic                      i_upper_byte_write_mask,
  input  wire logic [cmd_decode_pkg::DATA_W-1:0] i_rd_data,
  output cmd_decode_pkg::cmd_info_t      o_cmd,
  output logic                           o_cmd_valid,
  output logic [NUM_BANKS-1:0]           o_bank_active,
  output logic [2:0]                     o_pwr_state,
  output logic                           o_odt_en,
  output logic [cmd_decode_pkg::DATA_W-1:0] o_dq,
  output logic                           o_dq_oe_n,
  output logic                           o_dqs,
  output logic                           o_dqs_n,
  output logic                           o_dqs_oe_n,
  output logic [cmd_decode_pkg::DATA_W-1:0] o_wr_data,
  output logic [1:0]                     o_wr_byte_en,
  output logic                           o_wr_valid,
  input  wire logic                      i_wr_ready
);
  import cmd_decode_pkg::*;

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic [1:0]           rst_sync;
    logic [1:0]           ck_sync;
    logic [1:0]           dqs_sync;
    cmd_pins_t            pins_s1;
    cmd_pins_t            pins_s2;
    logic [DATA_W+1:0]    dq_s1;
    logic [DATA_W+1:0]    dq_s2;
    logic                 ck_prev;
    logic                 dqs_prev;
    logic                 cke_prev;
    pwr_t                 pwr;
    logic [NUM_BANKS-1:0] active;
    cmd_info_t            cmd;
    logic                 cmd_valid;
    logic [ADDR_W-1:0]    mr1;
    logic [ADDR_W-1:0]    mr2;
    logic                 odt_en;
    logic [3:0]           wr_left;
    logic [3:0]           rd_left;
    logic [BANK_W-1:0]    burst_bank;
    logic                 burst_ap;
    logic [DATA_W-1:0]    dq_out;
    logic                 dqs_out;
  } st_t;

  st_t       st_q;
  st_t       st_d;
  wr_beat_t  beat_in;
  logic      beat_valid;
  logic      fifo_ready;
  wr_beat_t  beat_out;
  logic      dev_rst;
  logic      ck_rise;
  logic      dqs_edge;
  logic      rtt_off;
  cmd_t      dec;
  cmd_pins_t p;

  // Pin reset is asynchronous; the device is held whole while it is low
  assign dev_rst  = !i_dram_reset_n || !st_q.rst_sync[1];
  assign p        = st_q.pins_s2;
  assign ck_rise  = st_q.ck_sync[1] && !st_q.ck_prev;
  assign dqs_edge = st_q.dqs_sync[1] ^ st_q.dqs_prev;
  // Both termination selects zero means the control pin is ignored
  assign rtt_off  = (st_q.mr1[MR1_RTT_LO] == 1'b0)
                 && (st_q.mr1[MR1_RTT_MI] == 1'b0)
                 && (st_q.mr1[MR1_RTT_HI] == 1'b0)
                 && (st_q.mr2[MR2_RTT_HI:MR2_RTT_LO] == 2'h0);

  // ***************************************************************
  // Truth-table decode
  // ***************************************************************
  always_comb begin
    dec = CMD_ILLEGAL;
    if (!st_q.cke_prev) begin
      // Only the exit is seen while clock enable was low
      if (p.cke && (p.cs_n || (p.ras_n && p.cas_n && p.we_n))) begin
        dec = CMD_LP_EXIT;
      end else begin
        dec = CMD_DESELECT;
      end
    end else if (p.cs_n) begin
      dec = p.cke ? CMD_DESELECT : CMD_PDOWN_IN;
    end else begin
      case ({p.ras_n, p.cas_n, p.we_n})
        // Only NOP and refresh have a meaning with enable falling
        3'b111: begin
          dec = p.cke ? CMD_NOP : CMD_PDOWN_IN;
        end
        3'b011: begin
          dec = p.cke ? CMD_ACTIVATE : CMD_ILLEGAL;
        end
        3'b010: begin
          dec = p.cke ? CMD_PRECHARGE : CMD_ILLEGAL;
        end
        3'b100: begin
          dec = p.cke ? CMD_WRITE : CMD_ILLEGAL;
        end
        3'b101: begin
          dec = p.cke ? CMD_READ : CMD_ILLEGAL;
        end
        3'b000: begin
          dec = p.cke ? CMD_MODE_SET : CMD_ILLEGAL;
        end
        3'b001: begin
          dec = p.cke ? CMD_REFRESH : CMD_SREF_IN;
        end
        3'b110: begin
          dec = p.cke ? CMD_CALIBRATE : CMD_ILLEGAL;
        end
        default: begin
          dec = CMD_ILLEGAL;
        end
      endcase
    end
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    st_d.rst_sync = {st_q.rst_sync[0], 1'b1};
    st_d.ck_sync  = {st_q.ck_sync[0], i_ck};
    st_d.dqs_sync = {st_q.dqs_sync[0], i_dqs};
    st_d.pins_s1  = i_pins;
    st_d.pins_s2  = st_q.pins_s1;
    st_d.dq_s1    = {i_dq, i_lower_byte_write_mask,
                     i_upper_byte_write_mask};
    st_d.dq_s2    = st_q.dq_s1;
    st_d.ck_prev  = st_q.ck_sync[1];
    st_d.dqs_prev = st_q.dqs_sync[1];
    st_d.cmd_valid = 1'b0;
    beat_valid = 1'b0;
    beat_in    = '0;

    // Bursts advance before the command is applied, so a command on the
    // same edge wins: an activate beats an auto-precharge close and a new
    // burst load beats the last count of the old one
    // Data beats on both strobe edges
    if (dqs_edge && st_q.wr_left != 4'h0 && fifo_ready) begin
      beat_in.data = st_q.dq_s2[DATA_W+1:2];
      beat_in.lower_byte_write_mask = st_q.dq_s2[1];
      beat_in.upper_byte_write_mask = st_q.dq_s2[0];
      beat_in.last = (st_q.wr_left == 4'h1);
      beat_valid = 1'b1;
      st_d.wr_left = st_q.wr_left - 4'h1;
      if (st_q.wr_left == 4'h1 && st_q.burst_ap) begin
        st_d.active[st_q.burst_bank] = 1'b0;
      end
    end
    // Read beats toggle the strobe out once per system cycle
    if (st_q.rd_left != 4'h0) begin
      st_d.dqs_out = !st_q.dqs_out;
      st_d.rd_left = st_q.rd_left - 4'h1;
      if (st_q.rd_left == 4'h1 && st_q.burst_ap) begin
        st_d.active[st_q.burst_bank] = 1'b0;
      end
    end else begin
      st_d.dqs_out = 1'b0;
    end

    if (ck_rise) begin
      st_d.cke_prev = p.cke;
      // Termination takes the registered control level
      st_d.odt_en = p.odt && !rtt_off && (st_q.pwr == PWR_ON);
      st_d.cmd.cmd  = dec;
      st_d.cmd.bank = p.bank;
      st_d.cmd.row  = p.addr;
      st_d.cmd.col  = p.addr[COL_W-1:0];
      st_d.cmd.auto_pre  = p.addr[AP_BIT];
      st_d.cmd.all_banks = p.addr[AP_BIT];
      st_d.cmd.cal_long  = p.addr[AP_BIT];
      // Low chop bit asks for four beats, high for eight
      st_d.cmd.beats = p.addr[BC_BIT] ? BEATS_EIGHT : BEATS_FOUR;
      st_d.cmd_valid = 1'b1;
      case (st_q.pwr)
        PWR_ON: begin
          case (dec)
            CMD_ACTIVATE: begin
              st_d.active[p.bank] = 1'b1;
            end
            CMD_PRECHARGE: begin
              if (p.addr[AP_BIT]) begin
                st_d.active = '0;
              end else begin
                st_d.active[p.bank] = 1'b0;
              end
            end
            CMD_WRITE: begin
              st_d.wr_left    = st_d.cmd.beats;
              st_d.burst_bank = p.bank;
              st_d.burst_ap   = p.addr[AP_BIT];
            end
            CMD_READ: begin
              st_d.rd_left    = st_d.cmd.beats;
              st_d.burst_bank = p.bank;
              st_d.burst_ap   = p.addr[AP_BIT];
            end
            CMD_MODE_SET: begin
              // A write with any bank open is dropped without effect
              if (st_q.active == '0) begin
                if (p.bank == MR_SEL_ONE) begin
                  st_d.mr1 = p.addr;
                end
                if (p.bank == MR_SEL_TWO) begin
                  st_d.mr2 = p.addr;
                end
              end
            end
            CMD_SREF_IN: begin
              // Entry with an open bank is refused; the part stays on
              if (st_q.active == '0) begin
                st_d.pwr = PWR_SREF;
              end
            end
            CMD_PDOWN_IN: begin
              st_d.pwr = PWR_PDOWN;
            end
            default: ;
          endcase
        end
        PWR_SREF, PWR_PDOWN: begin
          // Everything but the exit is ignored while powered down
          if (dec == CMD_LP_EXIT) begin
            st_d.pwr = PWR_ON;
          end
        end
        default: begin
          st_d.pwr = PWR_ON;
        end
      endcase
    end

    // Data loads together with the enable, so no driven beat is stale
    if (st_d.rd_left != 4'h0) begin
      st_d.dq_out = i_rd_data;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  // Pin reset clears without waiting for a clock edge
  always_ff @(posedge i_clk_sys or negedge i_dram_reset_n) begin
    if (!i_dram_reset_n) begin
      st_q <= '0;
      st_q.pwr <= PWR_ON;
    end else if (!i_resetn) begin
      st_q <= '0;
      st_q.pwr <= PWR_ON;
    end else begin
      st_q <= st_d;
    end
  end

  // ***************************************************************
  // Write beat buffer
  // ***************************************************************
  // The sink can stall; a full buffer drops beats and that is a limit
  beat_fifo #(
    .WIDTH (WR_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn && !dev_rst),
    .i_data    (beat_in),
    .i_valid   (beat_valid),
    .o_ready   (fifo_ready),
    .o_data    (beat_out),
    .o_valid   (o_wr_valid),
    .i_ready   (i_wr_ready)
  );

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign o_cmd         = st_q.cmd;
  assign o_cmd_valid   = st_q.cmd_valid;
  assign o_bank_active = st_q.active;
  assign o_pwr_state   = st_q.pwr;
  // Termination reaches every data line and both strobe lines
  assign o_odt_en      = st_q.odt_en;
  assign o_wr_data     = beat_out.data;
  // A high mask means the byte lane is not written; lanes act alone
  logic [DATA_W/BYTE_W-1:0] lane_mask;
  assign lane_mask = {beat_out.upper_byte_write_mask,
                      beat_out.lower_byte_write_mask};
  for (genvar g = 0; g < DATA_W / BYTE_W; g++) begin : g_lane
    assign o_wr_byte_en[g] = !lane_mask[g];
  end
  assign o_dq          = st_q.dq_out;
  assign o_dqs         = st_q.dqs_out;
  assign o_dqs_n       = !st_q.dqs_out;
  assign o_dq_oe_n     = (st_q.rd_left == 4'h0);
  assign o_dqs_oe_n    = (st_q.rd_left == 4'h0);

endmodule : dram_cmd_decoder

// ### sim/dram_cmd_decoder_chk.sv
/* Checker for the command decoder outputs.
   Assumes it is bound to the decoder top module. */
`timescale 1ns/1ps
module dram_cmd_decoder_chk #(
  parameter int NUM_BANKS = 8
) (
  input wire logic                         i_clk_sys,
  input wire logic                         i_resetn,
  input wire logic                         i_dram_reset_n,
  input wire logic                         i_wr_ready,
  input wire cmd_decode_pkg::cmd_info_t    o_cmd,
  input wire logic                         o_cmd_valid,
  input wire logic [NUM_BANKS-1:0]         o_bank_active,
  input wire logic [2:0]                   o_pwr_state,
  input wire logic                         o_dq_oe_n,
  input wire logic [cmd_decode_pkg::DATA_W-1:0] o_wr_data,
  input wire logic                         o_wr_valid
);
  import cmd_decode_pkg::*;
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn || !i_dram_reset_n);
  // Command clock is at least four cycles, so reports stay apart
  a_report_pulse: assert property (
    o_cmd_valid |=> !o_cmd_valid [*3]) else $error("report too long");
  a_pwr_onehot: assert property (
    $onehot(o_pwr_state)) else $error("power state not one-hot");
  a_act_opens: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_ACTIVATE |->
      ##[0:1] o_bank_active[o_cmd.bank]) else $error("bank not opened");
  a_pre_all: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_PRECHARGE && o_cmd.all_banks |->
      ##[0:1] o_bank_active == '0) else $error("banks not closed");
  // A refused entry with open banks must not be judged here
  a_sref_entry: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_SREF_IN && o_bank_active == '0 |->
      ##[0:1] o_pwr_state == PWR_SREF) else $error("no self refresh");
  a_pdown_entry: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_PDOWN_IN |->
      ##[0:1] o_pwr_state == PWR_PDOWN) else $error("no power down");
  a_lp_exit: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_LP_EXIT |->
      ##[0:1] o_pwr_state == PWR_ON) else $error("no low power exit");
  a_read_drive: assert property (
    o_cmd_valid && o_cmd.cmd == CMD_READ |-> ##[0:4] !o_dq_oe_n)
    else $error("read data not driven");
  a_fifo_hold: assert property (
    o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr_data))
    else $error("stalled write word lost");
  a_reset_clear: assert property (
    disable iff (!i_resetn)
    !i_dram_reset_n |-> o_bank_active == '0 && o_pwr_state == PWR_ON)
    else $error("device reset did not clear state");
endmodule : dram_cmd_decoder_chk

bind dram_cmd_decoder dram_cmd_decoder_chk #(.NUM_BANKS(NUM_BANKS))
  chk_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
  .i_dram_reset_n(i_dram_reset_n), .i_wr_ready(i_wr_ready),
  .o_cmd(o_cmd), .o_cmd_valid(o_cmd_valid), .o_bank_active(o_bank_active),
  .o_pwr_state(o_pwr_state), .o_dq_oe_n(o_dq_oe_n),
  .o_wr_data(o_wr_data), .o_wr_valid(o_wr_valid));

// ### sim/dram_ctrl_model.sv
/* Controller model: command clock, command pins and write beats.
   Assumes its tasks are called just after a falling system edge. */
`timescale 1ns/1ps
module dram_ctrl_model (
  input  wire logic                         i_clk_sys,
  output logic                              o_ck,
  output cmd_decode_pkg::cmd_pins_t         o_pins,
  output logic                              o_dqs,
  output logic [cmd_decode_pkg::DATA_W-1:0] o_dq,
  output logic                              o_lo_mask,
  output logic                              o_hi_mask
);
  import cmd_decode_pkg::*;
  // ****************
  // Drivers
  // ****************
  // Clock parked low outside frames; deselect with enable low at start
  initial begin
    o_ck = 1'b0;
    o_dqs = 1'b0;
    o_dq = 16'h0000;
    o_lo_mask = 1'b0;
    o_hi_mask = 1'b0;
    o_pins = cmd_pins_t'{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 3'h0, 15'h0};
  end
  // One frame: pins held, clock low four then high four cycles
  task automatic cmd(input logic [3:0] c, input logic k,
                     input logic [2:0] b, input logic [14:0] a,
                     input logic t);
    o_pins = cmd_pins_t'{c[3], c[2], c[1], c[0], k, t, b, a};
    repeat (4) @(negedge i_clk_sys);
    o_ck = 1'b1;
    repeat (4) @(negedge i_clk_sys);
    o_ck = 1'b0;
  endtask : cmd
  // Beats on every strobe edge, rising and falling; data inverted once released
  task automatic beats(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      o_dq = base + 16'(i);
      o_lo_mask = i[0];
      o_hi_mask = i[1];
      repeat (2) @(negedge i_clk_sys);
      o_dqs = ~o_dqs;
      repeat (3) @(negedge i_clk_sys);
    end
    o_dq = ~o_dq;
  endtask : beats
endmodule : dram_ctrl_model

// ### sim/dram_cmd_decoder_test.sv
/* Bench for the command decoder, driven through the controller model.
   Assumes package, decoder, buffer, model and checker are compiled. */
`timescale 1ns/1ps
module dram_cmd_decoder_test;
  import cmd_decode_pkg::*;
  // ****************
  // Harness
  // ****************
  localparam logic [3:0] C_NOP = 4'h7, C_DES = 4'h8, C_ACT = 4'h3;
  localparam logic [3:0] C_RD = 4'h5, C_WR = 4'h4, C_PRE = 4'h2;
  localparam logic [3:0] C_MRS = 4'h0, C_REF = 4'h1, C_ZQ = 4'h6;
  logic                 clk_sys, resetn, dram_reset_n, wr_ready, odt;
  logic [DATA_W-1:0]    rd_data, dq, dq_out, wr_data;
  logic                 ck, dqs, lo_mask, hi_mask, rep_valid, odt_en;
  logic                 dq_oe_n, wr_valid, rd_dqs, rd_dqs_n, rd_dqs_oe_n;
  logic [NUM_BANKS-1:0] bank_act;
  logic [2:0]           pwr;
  logic [1:0]           wr_be;
  cmd_pins_t            pins;
  cmd_info_t            rep, last;
  int                   mismatches = 0, comparisons = 0, nrep = 0;
  int                   ndrive = 0;

  dram_cmd_decoder dram_cmd_decoder_inst (
    .i_clk_sys(clk_sys), .i_resetn(resetn), .i_dram_reset_n(dram_reset_n),
    .i_ck(ck), .i_pins(pins), .i_dqs(dqs), .i_dq(dq),
    .i_lower_byte_write_mask(lo_mask), .i_upper_byte_write_mask(hi_mask),
    .i_rd_data(rd_data), .o_cmd(rep), .o_cmd_valid(rep_valid),
    .o_bank_active(bank_act), .o_pwr_state(pwr), .o_odt_en(odt_en),
    .o_dq(dq_out), .o_dq_oe_n(dq_oe_n), .o_dqs(rd_dqs),
    .o_dqs_n(rd_dqs_n), .o_dqs_oe_n(rd_dqs_oe_n), .o_wr_data(wr_data),
    .o_wr_byte_en(wr_be),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready));
  dram_ctrl_model dram_ctrl_model_inst (.i_clk_sys(clk_sys), .o_ck(ck),
    .o_pins(pins), .o_dqs(dqs), .o_dq(dq), .o_lo_mask(lo_mask),
    .o_hi_mask(hi_mask));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Latch reports and judge every driven read beat
  always @(negedge clk_sys) begin
    if (rep_valid === 1'b1) begin
      last = rep;
      nrep++;
    end
    if (dq_oe_n === 1'b0) begin
      ndrive++;
      chk("read data", rd_data, dq_out);
      chk("strobe enable", 0, rd_dqs_oe_n);
      chk("strobe pair", 1, rd_dqs ^ rd_dqs_n);
    end
  end
  // One frame; CMD_ILLEGAL as expectation skips the code check
  task automatic send(input logic [3:0] c, input logic k,
                      input logic [2:0] b, input logic [14:0] a,
                      input cmd_t e);
    int n0;
    n0 = nrep;
    dram_ctrl_model_inst.cmd(c, k, b, a, odt);
    repeat (3) @(negedge clk_sys);
    chk("report count", 1, nrep - n0);
    if (e != CMD_ILLEGAL) chk("report code", e, last.cmd);
  endtask : send
  // Drain the buffer a word a cycle after a stall
  task automatic drain(input int n, input logic [15:0] base);
    for (int i = 0; i < n; i++) begin
      chk("write valid", 1, wr_valid);
      chk("write data", base + 16'(i), wr_data);
      chk("byte enables", 2'(~i[1:0]), wr_be);
      wr_ready = 1'b1;
      @(negedge clk_sys);
    end
    wr_ready = 1'b0;
    chk("buffer empty", 0, wr_valid);
  endtask : drain
  // ****************
  // Scenarios
  // ****************
  task automatic t_codes();
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_LP_EXIT);
    send(C_NOP, 1'b1, 3'h5, 15'h7fff, CMD_NOP);
    send(C_DES, 1'b1, 3'h0, 15'h0, CMD_DESELECT);
    chk("banks after deselect", 0, bank_act);
    send(C_ZQ, 1'b1, 3'h0, 15'h0400, CMD_CALIBRATE);
    chk("long calibration", 1, last.cal_long);
    send(C_ZQ, 1'b1, 3'h0, 15'h0000, CMD_CALIBRATE);
    chk("short calibration", 0, last.cal_long);
    send(C_REF, 1'b1, 3'h0, 15'h0, CMD_REFRESH);
  endtask : t_codes
  task automatic t_power();
    send(C_REF, 1'b0, 3'h0, 15'h0, CMD_SREF_IN);
    chk("self refresh", PWR_SREF, pwr);
    send(C_ACT, 1'b0, 3'h1, 15'h0, CMD_ILLEGAL);
    chk("banks in self refresh", 0, bank_act);
    chk("still self refresh", PWR_SREF, pwr);
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_LP_EXIT);
    chk("awake", PWR_ON, pwr);
    send(C_NOP, 1'b0, 3'h0, 15'h0, CMD_PDOWN_IN);
    chk("power down", PWR_PDOWN, pwr);
    send(C_DES, 1'b1, 3'h0, 15'h0, CMD_LP_EXIT);
    chk("awake again", PWR_ON, pwr);
  endtask : t_power
  // Activate only idle banks, access only open ones
  task automatic t_access();
    int n0;
    send(C_ACT, 1'b1, 3'h3, 15'h1234, CMD_ACTIVATE);
    chk("row", 15'h1234, last.row);
    chk("bank open", 8'h08, bank_act);
    n0 = ndrive;
    send(C_RD, 1'b1, 3'h3, 15'h19a5, CMD_READ);
    chk("read beats", BEATS_EIGHT, last.beats);
    chk("column", 10'h1a5, last.col);
    chk("no auto close", 0, last.auto_pre);
    repeat (12) @(negedge clk_sys);
    chk("driven beats", 8, ndrive - n0);
    send(C_WR, 1'b1, 3'h3, 15'h0010, CMD_WRITE);
    chk("chopped beats", BEATS_FOUR, last.beats);
    dram_ctrl_model_inst.beats(4, 16'ha000);
    drain(4, 16'ha000);
    chk("bank kept open", 8'h08, bank_act);
    send(C_WR, 1'b1, 3'h3, 15'h1400, CMD_WRITE);
    chk("write beats", BEATS_EIGHT, last.beats);
    chk("auto close", 1, last.auto_pre);
    dram_ctrl_model_inst.beats(8, 16'hb000);
    drain(8, 16'hb000);
    chk("bank closed", 0, bank_act);
  endtask : t_access
  task automatic t_odt_pre();
    odt = 1'b1;
    send(C_MRS, 1'b1, 3'h1, 15'h0, CMD_MODE_SET);
    send(C_MRS, 1'b1, 3'h2, 15'h0, CMD_MODE_SET);
    chk("termination ignored", 0, odt_en);
    send(C_MRS, 1'b1, 3'h1, 15'h0004, CMD_MODE_SET);
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_NOP);
    chk("termination on", 1, odt_en);
    send(C_ACT, 1'b1, 3'h1, 15'h0, CMD_ACTIVATE);
    send(C_ACT, 1'b1, 3'h2, 15'h0, CMD_ACTIVATE);
    send(C_PRE, 1'b1, 3'h1, 15'h0, CMD_PRECHARGE);
    chk("one bank closed", 8'h04, bank_act);
    send(C_MRS, 1'b1, 3'h1, 15'h0, CMD_ILLEGAL);
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_NOP);
    chk("mode set refused", 1, odt_en);
    odt = 1'b0;
    send(C_PRE, 1'b1, 3'h5, 15'h0400, CMD_PRECHARGE);
    chk("all banks closed", 0, bank_act);
    chk("termination off", 0, odt_en);
  endtask : t_odt_pre
  task automatic t_reset();
    send(C_ACT, 1'b1, 3'h0, 15'h0, CMD_ACTIVATE);
    send(C_REF, 1'b0, 3'h0, 15'h0, CMD_SREF_IN);
    chk("refused self refresh", PWR_ON, pwr);
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_LP_EXIT);
    dram_reset_n = 1'b0;
    #1;
    chk("banks at reset", 0, bank_act);
    repeat (2) @(negedge clk_sys);
    dram_reset_n = 1'b1;
    send(C_NOP, 1'b1, 3'h0, 15'h0, CMD_LP_EXIT);
  endtask : t_reset
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    stop_test();
  end
  initial begin
    resetn = 1'b0;
    dram_reset_n = 1'b1;
    wr_ready = 1'b0;
    odt = 1'b0;
    rd_data = 16'hc3a5;
    repeat (12) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_codes();
    t_power();
    t_access();
    t_odt_pre();
    t_reset();
    stop_test();
  end
endmodule : dram_cmd_decoder_test
